// File: hw/vbsl_pkg.sv
/*
 * Package for the VME buffer control and strap loader: reset counts, strap widths, direction encodings.
 * Assumes a single 25 MHz core clock feeding every consumer.
 */
package vbsl_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // Contention guard: one 64 MHz period in ns (15.625, rounded up to whole ns)
    localparam int GUARD_TIME_NS = 16;
    localparam int GUARD_CYCLES = (GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Transceiver enable hold-off after system reset, in core cycles
    localparam int OE_HOLD_CYCLES = 8;
    localparam int ADDR_W = 31;
    localparam int DATA_STRAP_W = 5;
    localparam logic [30:0] ADDR_STRAP_RESET = 31'h0000_0000;
    localparam logic [4:0] DATA_STRAP_RESET = 5'h00;
    localparam logic DIR_OUT = 1'b1;
    localparam logic DIR_IN = 1'b0;
    typedef enum logic [1:0] {
        VBSL_IDLE = 2'b00,
        VBSL_DRIVE = 2'b01,
        VBSL_GUARD = 2'b11
    } vbsl_dir_e;
endpackage : vbsl_pkg

// File: hw/vbsl_dir_if.sv
/*
 * Interface carrying one direction group's request and resulting controls.
 * Assumes the control module and its owner share ref_clk_i.
 */
`timescale 1ns/10ps
interface vbsl_dir_if;
    logic drive_req;
    logic buf_dir;
    logic pin_oe;
    modport ctrl (input drive_req, output buf_dir, output pin_oe);
    modport user (output drive_req, input buf_dir, input pin_oe);
endinterface : vbsl_dir_if

// File: hw/vbsl_dir_ctrl.sv
/*
 * One transceiver direction group: drops own output enable a guard period before the buffer turns inward.
 * Assumes drive_req is synchronous to ref_clk_i and rst_i is synchronous.
 */
`timescale 1ns/10ps
module vbsl_dir_ctrl (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    vbsl_dir_if.ctrl grp
);
    import vbsl_pkg::*;
    vbsl_dir_e state;
    vbsl_dir_e next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            VBSL_IDLE: begin
                if (grp.drive_req) begin
                    next_state = VBSL_DRIVE;
                end
            end
            VBSL_DRIVE: begin
                if (!grp.drive_req) begin
                    next_state = VBSL_GUARD;
                    next_cnt = 4'(GUARD_CYCLES);
                end
            end
            VBSL_GUARD: begin
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    next_state = VBSL_IDLE;
                end
            end
            default: next_state = VBSL_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= VBSL_IDLE;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Pins released first, buffer stays outward through the guard state
    assign grp.pin_oe = (state == VBSL_DRIVE);
    assign grp.buf_dir = (state == VBSL_IDLE) ? DIR_IN : DIR_OUT;

    chk_guard_before_turn: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(grp.pin_oe) |-> grp.buf_dir == DIR_OUT)
        else $error("Buffer turned inward while pins still driven");
    chk_no_drive_inward: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        grp.pin_oe |-> grp.buf_dir == DIR_OUT)
        else $error("Pins driven with buffer facing inward");
endmodule : vbsl_dir_ctrl

// File: hw/vbsl_top.sv
/*
 * VME transceiver direction control, transceiver enable sequencing and power-up strap capture.
 * Assumes all inputs synchronous to ref_clk_i; power_on_reset_n and sys_reset_n are active-low levels.
 */
// Notes on behaviour
// - Driving the bus sets direction controls high
// - Bus driving device sets direction controls low
// - Address strobe direction controlled on its own
// - Tristate own outputs before turning inward
// - Address and data pins undriven during reset
// - Transceiver enable off during and after reset
// - Capture straps at power-up reset rising edge
// - Undriven strap pins default low, inactive
// - Sample bus grant at reset end for syscon
`timescale 1ns/10ps
module vbsl_top #(
    parameter int OE_HOLD = vbsl_pkg::OE_HOLD_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic power_on_reset_n_i,
    input wire logic sys_reset_n_i,
    input wire logic bus_grant_in3_i,
    input wire logic addr_drive_req_i,
    input wire logic modifier_drive_req_i,
    input wire logic strobe_drive_req_i,
    input wire logic databus_drive_req_i,
    input wire logic datastrobe_drive_req_i,
    input wire logic slave_resp_drive_req_i,
    input wire logic syscon_drive_req_i,
    input wire logic [vbsl_pkg::ADDR_W-1:0] bridge_addr_pins_i,
    input wire logic [vbsl_pkg::DATA_STRAP_W-1:0] bridge_data_strap_i,
    output logic addr_buf_dir_o,
    output logic modifier_buf_dir_o,
    output logic strobe_buf_dir_o,
    output logic databus_buf_dir_o,
    output logic datastrobe_buf_dir_o,
    output logic slave_resp_buf_dir_o,
    output logic syscon_buf_dir_o,
    output logic addr_pins_oe_o,
    output logic data_pins_oe_o,
    output logic strobe_pins_oe_o,
    output logic xcvr_out_enable_n_o,
    output logic [vbsl_pkg::ADDR_W-1:0] addr_strap_o,
    output logic [vbsl_pkg::DATA_STRAP_W-1:0] data_strap_o,
    output logic syscon_enable_o
);
    import vbsl_pkg::*;
    localparam int NGRP = 7;

    logic any_reset;
    logic [NGRP-1:0] req;
    logic [NGRP-1:0] dirs;
    logic [NGRP-1:0] oes;
    logic por_n_q;
    logic sys_n_q;
    logic [7:0] oe_cnt;
    logic [7:0] next_oe_cnt;
    logic [ADDR_W-1:0] addr_strap;
    logic [ADDR_W-1:0] next_addr_strap;
    logic [DATA_STRAP_W-1:0] data_strap;
    logic [DATA_STRAP_W-1:0] next_data_strap;
    logic syscon_en;
    logic next_syscon_en;

    assign any_reset = rst_i | !power_on_reset_n_i | !sys_reset_n_i;
    // Requests are ignored in reset so pins stay free for straps
    assign req = any_reset ? '0 : {syscon_drive_req_i, slave_resp_drive_req_i, datastrobe_drive_req_i,
        databus_drive_req_i, strobe_drive_req_i, modifier_drive_req_i, addr_drive_req_i};

    // Each group, the strobe one included, turns around on its own schedule
    generate
        for (genvar g = 0; g < NGRP; g++) begin : g_grp
            vbsl_dir_if gi ();
            assign gi.drive_req = req[g];
            assign dirs[g] = gi.buf_dir;
            assign oes[g] = gi.pin_oe;
            vbsl_dir_ctrl u_ctrl (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .grp(gi)
            );
        end
    endgenerate

    assign addr_buf_dir_o = dirs[0];
    assign modifier_buf_dir_o = dirs[1];
    assign strobe_buf_dir_o = dirs[2];
    assign databus_buf_dir_o = dirs[3];
    assign datastrobe_buf_dir_o = dirs[4];
    assign slave_resp_buf_dir_o = dirs[5];
    assign syscon_buf_dir_o = dirs[6];
    assign addr_pins_oe_o = oes[0] & !any_reset;
    assign data_pins_oe_o = oes[3] & !any_reset;
    assign strobe_pins_oe_o = oes[2];

    always_comb begin
        next_oe_cnt = oe_cnt;
        next_addr_strap = addr_strap;
        next_data_strap = data_strap;
        next_syscon_en = syscon_en;
        if (!sys_reset_n_i || !power_on_reset_n_i) begin
            next_oe_cnt = 8'(OE_HOLD);
        end else if (oe_cnt != 8'h0) begin
            next_oe_cnt = oe_cnt - 8'h1;
        end
        // Undriven pins read low through pull-downs, giving the inactive option
        if (power_on_reset_n_i && !por_n_q) begin
            next_addr_strap = bridge_addr_pins_i;
            next_data_strap = bridge_data_strap_i;
        end
        if (sys_reset_n_i && !sys_n_q) begin
            next_syscon_en = !bus_grant_in3_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oe_cnt <= 8'(OE_HOLD);
            // Edge detectors rest at the released level, so a core reset never fakes a release
            // Limitation: a power-up release that falls inside a core reset is not seen
            por_n_q <= 1'b1;
            sys_n_q <= 1'b1;
            syscon_en <= 1'b0;
        end else begin
            oe_cnt <= next_oe_cnt;
            por_n_q <= power_on_reset_n_i;
            sys_n_q <= sys_reset_n_i;
            syscon_en <= next_syscon_en;
        end
    end

    // Straps survive the core reset; only a new power-up edge reloads them
    always_ff @(posedge ref_clk_i) begin
        addr_strap <= next_addr_strap;
        data_strap <= next_data_strap;
    end

    // Enable stays off during the hold-off so strap drivers may release
    assign xcvr_out_enable_n_o = any_reset | (oe_cnt != 8'h0);
    assign addr_strap_o = addr_strap;
    assign data_strap_o = data_strap;
    assign syscon_enable_o = syscon_en;

    chk_oe_hold_after: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(sys_reset_n_i) && power_on_reset_n_i |-> xcvr_out_enable_n_o [*8])
        else $error("Transceiver enabled too soon after reset");
    chk_pins_free_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !power_on_reset_n_i || !sys_reset_n_i |-> !addr_pins_oe_o && !data_pins_oe_o)
        else $error("Address or data pins driven during reset");
    chk_strap_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        power_on_reset_n_i && !por_n_q |=> addr_strap_o == $past(bridge_addr_pins_i)
        && data_strap_o == $past(bridge_data_strap_i))
        else $error("Straps not captured at power-up release");
    chk_strap_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        por_n_q && power_on_reset_n_i |=> $stable(addr_strap_o) && $stable(data_strap_o))
        else $error("Straps changed without power-up reset");
    chk_syscon_sample: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sys_reset_n_i && !sys_n_q |=> syscon_enable_o == !$past(bus_grant_in3_i))
        else $error("Syscon enable not sampled from bus grant");
    chk_dir_out_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        addr_pins_oe_o |-> addr_buf_dir_o == DIR_OUT)
        else $error("Address driven with buffer inward");
    chk_dir_in_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !databus_drive_req_i && !data_pins_oe_o ##1 !databus_drive_req_i && !data_pins_oe_o
        |=> databus_buf_dir_o == DIR_IN)
        else $error("Data buffer not turned inward when idle");
    chk_strobe_guard: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(strobe_pins_oe_o) |-> strobe_buf_dir_o == DIR_OUT ##1 strobe_buf_dir_o == DIR_IN)
        else $error("Strobe turnaround guard period wrong");
    chk_dir_out_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        data_pins_oe_o |-> databus_buf_dir_o == DIR_OUT)
        else $error("Data driven with buffer inward");
    chk_enable_in_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !sys_reset_n_i || !power_on_reset_n_i |-> xcvr_out_enable_n_o)
        else $error("Transceiver enabled during reset");
    chk_oe_hold_power: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(power_on_reset_n_i) && sys_reset_n_i |-> xcvr_out_enable_n_o [*8])
        else $error("Transceiver enabled too soon after power-up");
    chk_addr_turn: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(addr_pins_oe_o) |-> addr_buf_dir_o == DIR_OUT)
        else $error("Address buffer turned inward while pins driven");
    chk_data_turn: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(data_pins_oe_o) |-> databus_buf_dir_o == DIR_OUT)
        else $error("Data buffer turned inward while pins driven");
    chk_syscon_steady: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(sys_reset_n_i && !sys_n_q) |=> $stable(syscon_enable_o))
        else $error("Syscon enable changed outside system reset release");

    // The multi-step checks below are built from named sequences
    sequence s_resets_clear;
        sys_reset_n_i && power_on_reset_n_i;
    endsequence

    sequence s_sys_release;
        $rose(sys_reset_n_i) && power_on_reset_n_i;
    endsequence

    sequence s_addr_quiet;
        !addr_drive_req_i && !addr_pins_oe_o;
    endsequence

    sequence s_strobe_idle_req;
        strobe_drive_req_i && !any_reset && strobe_buf_dir_o == DIR_IN;
    endsequence

    sequence s_strobe_driving;
        strobe_buf_dir_o == DIR_OUT && strobe_pins_oe_o;
    endsequence

    chk_enable_return: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_sys_release ##0 s_resets_clear [*8] |=> !xcvr_out_enable_n_o || !sys_reset_n_i || !power_on_reset_n_i)
        else $error("Transceiver enable not restored after hold-off");
    chk_addr_idle_in: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_addr_quiet ##1 s_addr_quiet |=> addr_buf_dir_o == DIR_IN)
        else $error("Address buffer not turned inward when idle");
    chk_strobe_own: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_strobe_idle_req |=> s_strobe_driving)
        else $error("Strobe group did not follow its own request");
endmodule : vbsl_top

// File: test/vbsl_strap_model.sv
/*
 * Active strap circuitry and VMEbus traffic seen at the bridge address/data pins.
 * Assumes pull-downs: pins read 0 when nothing drives them.
 */
`timescale 1ns/10ps
module vbsl_strap_model (
    input wire logic ref_clk_i,
    input wire logic xcvr_out_enable_n_i,
    input wire logic strap_on_i,
    input wire logic [35:0] strap_val_i,
    output logic [vbsl_pkg::ADDR_W-1:0] addr_o,
    output logic [vbsl_pkg::DATA_STRAP_W-1:0] data_o
);
    logic [35:0] traffic = 36'h0;
    // Bus traffic moves every cycle so a stale capture cannot pass as held
    always @(negedge ref_clk_i) begin
        traffic <= traffic + 36'h1234567;
    end
    always_comb begin
        if (xcvr_out_enable_n_i === 1'b1) begin
            {addr_o, data_o} = strap_on_i ? strap_val_i : 36'h0;
        end else begin
            {addr_o, data_o} = traffic;
        end
    end
endmodule : vbsl_strap_model

// File: test/tb_top.sv
/*
 * Self-checking bench for vbsl_top with the strap and bus model.
 * Assumes inputs change on the falling edge of ref_clk_i.
 */
`timescale 1ns/10ps
module tb_top;
    import vbsl_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic power_on_reset_n = 1'b0;
    logic sys_reset_n = 1'b1;
    logic grant = 1'b1;
    logic strap_on = 1'b0;
    logic [6:0] req = 7'h00;
    logic [6:0] dir;
    logic aoe, doe, soe, en_n, syscon;
    logic [35:0] strap_val = 36'h0;
    logic [ADDR_W-1:0] pins_a, strap_a;
    logic [DATA_STRAP_W-1:0] pins_d, strap_d;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    vbsl_top #(.OE_HOLD(OE_HOLD_CYCLES)) vbsl_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .power_on_reset_n_i(power_on_reset_n), .sys_reset_n_i(sys_reset_n), .bus_grant_in3_i(grant),
        .addr_drive_req_i(req[0]), .modifier_drive_req_i(req[1]), .strobe_drive_req_i(req[2]),
        .databus_drive_req_i(req[3]), .datastrobe_drive_req_i(req[4]), .slave_resp_drive_req_i(req[5]),
        .syscon_drive_req_i(req[6]), .bridge_addr_pins_i(pins_a), .bridge_data_strap_i(pins_d),
        .addr_buf_dir_o(dir[0]), .modifier_buf_dir_o(dir[1]), .strobe_buf_dir_o(dir[2]),
        .databus_buf_dir_o(dir[3]), .datastrobe_buf_dir_o(dir[4]), .slave_resp_buf_dir_o(dir[5]),
        .syscon_buf_dir_o(dir[6]), .addr_pins_oe_o(aoe), .data_pins_oe_o(doe), .strobe_pins_oe_o(soe),
        .xcvr_out_enable_n_o(en_n), .addr_strap_o(strap_a), .data_strap_o(strap_d),
        .syscon_enable_o(syscon));
    vbsl_strap_model vbsl_strap_model_i (.ref_clk_i(ref_clk_i), .xcvr_out_enable_n_i(en_n),
        .strap_on_i(strap_on), .strap_val_i(strap_val), .addr_o(pins_a), .data_o(pins_d));
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic nx(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : nx
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Limit sized well above the hundred or so cycles the tests need
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            $display("Error timeout expected finish seen hang");
            end_sim();
        end
    end
    task automatic t_dir();
        for (int g = 0; g < 7; g++) begin
            req = 7'h01 << g;
            nx(1);
            chk("dir out", 36'(req), 36'(dir));
            chk("pin oe", {33'h0, g == 0, g == 3, g == 2}, 36'({aoe, doe, soe}));
            req = 7'h00;
            nx(1);
            chk("pin oe guard", 36'h0, 36'({aoe, doe, soe}));
            chk("dir guard", 36'(7'h01 << g), 36'(dir));
            nx(1);
            chk("dir in", 36'h0, 36'(dir));
        end
        $display("t_dir done");
    endtask : t_dir
    task automatic t_sys(input logic g);
        int n;
        req = 7'h09;
        grant = g;
        sys_reset_n = 1'b0;
        nx(2);
        chk("pin oe in reset", 36'h0, 36'({aoe, doe}));
        chk("enable in reset", 36'h1, 36'(en_n));
        sys_reset_n = 1'b1;
        nx(1);
        chk("syscon", 36'(!g), 36'(syscon));
        n = 1;
        while (en_n !== 1'b0 && n < 50) begin
            nx(1);
            n++;
        end
        chk("enable hold", 36'(OE_HOLD_CYCLES), 36'(n));
        req = 7'h00;
        nx(2);
        $display("t_sys done");
    endtask : t_sys
    task automatic t_strap(input logic on, input logic [35:0] v);
        strap_on = on;
        strap_val = v;
        power_on_reset_n = 1'b0;
        nx(2);
        power_on_reset_n = 1'b1;
        nx(1);
        chk("straps", on ? v : 36'h0, {strap_a, strap_d});
        strap_on = 1'b0;
        nx(OE_HOLD_CYCLES + 4);
        chk("straps held", on ? v : 36'h0, {strap_a, strap_d});
        $display("t_strap done");
    endtask : t_strap
    initial begin
        nx(16);
        chk("dir in reset", 36'h0, 36'(dir));
        chk("enable in reset", 36'h1, 36'(en_n));
        rst_i = 1'b0;
        nx(1);
        power_on_reset_n = 1'b1;
        nx(OE_HOLD_CYCLES + 2);
        t_dir();
        t_sys(1'b0);
        t_sys(1'b1);
        t_strap(1'b1, 36'h9_a5c3_0f6b);
        t_strap(1'b0, 36'hf_ffff_ffff);
        // Live strap drive across a core reset must not be recaptured
        strap_on = 1'b1;
        rst_i = 1'b1;
        nx(2);
        rst_i = 1'b0;
        nx(1);
        chk("straps after core reset", 36'h0, {strap_a, strap_d});
        end_sim();
    end
endmodule : tb_top
